// file: core/isd_consts.vh
// Constants for the interrupt split descriptor engine.
// Assumes a 250 MHz system clock and 32-bit AXI4-Lite register access.
`ifndef ISD_CONSTS_VH
`define ISD_CONSTS_VH
// ==========================================================
// Timing
`define ISD_CLK_MHZ        250
`define ISD_UFRAME_NS      125000
`define ISD_UFRAME_CYCLES  ((`ISD_UFRAME_NS * `ISD_CLK_MHZ) / 1000)
// ==========================================================
// Byte map
`define ISD_DESC_TOP       8'h7c
`define ISD_CTRL_ADDR      8'h80
`define ISD_STAT_ADDR      8'h84
`define ISD_CTRL_RESET     1'b0
`define ISD_RESP_OKAY      2'b00
`define ISD_RESP_SLVERR    2'b10
// ==========================================================
// Descriptor word 0
`define ISD_DW0_VALID      0
`define ISD_DW0_LEN_HI     17
`define ISD_DW0_LEN_LO     3
`define ISD_DW0_MPS_HI     28
`define ISD_DW0_MPS_LO     18
`define ISD_DW0_EP0        31
// Descriptor word 1
`define ISD_DW1_EP_HI      2
`define ISD_DW1_EP_LO      0
`define ISD_DW1_DEV_HI     9
`define ISD_DW1_DEV_LO     3
`define ISD_DW1_TOK_HI     11
`define ISD_DW1_TOK_LO     10
`define ISD_DW1_TYPE_HI    13
`define ISD_DW1_TYPE_LO    12
`define ISD_DW1_SPLIT      14
`define ISD_DW1_SE_HI      17
`define ISD_DW1_SE_LO      16
`define ISD_DW1_PORT_HI    24
`define ISD_DW1_PORT_LO    18
`define ISD_DW1_HUB_HI     31
`define ISD_DW1_HUB_LO     25
// Descriptor word 2
`define ISD_DW2_POLL_HI    7
`define ISD_DW2_POLL_LO    3
`define ISD_DW2_ADDR_HI    23
`define ISD_DW2_ADDR_LO    8
// Descriptor word 3
`define ISD_DW3_MOVED_HI   11
// ==========================================================
// Encodings and limits
`define ISD_TYPE_INTR      2'b11
`define ISD_SE_LOW         2'b10
`define ISD_SE_FULL        2'b00
`define ISD_FSLS_MAX_MPS   11'h040
`define ISD_MAX_LEN        15'h1000
`define ISD_LAST_SLOT      3'h7
`endif

// file: core/isd_desc_engine.v
// Periodic interrupt descriptor engine with start/complete split support.
// Assumes a transaction engine on clk_sys that answers each txnStart with txnDone.
// How it works
// - The endpoint number is word1 bits 2:0 above word0 bit 31.
// - Max packet length sits in word0 28:18; split full/low-speed above 64 is rejected.
// - Byte count sits in word0 17:3; counts above 4096 are rejected.
// - Valid is cleared when the descriptor finishes or hits a fatal error.
// - The five-bit polling field selects 1, 2, 4, 8, 16 or 32 ms by leading one.
// - Split speed 10 is low-speed, 00 full-speed; other codes are rejected when the split bit is set.
// - Split bit selects split or high-speed; type 11 is interrupt; token 00 OUT, 01 IN.
// - The poll interval is 2^(b+4) microframes for a leading one at bit b, 8 if the field is zero, 8 microframes being one ms.
// - Bytes actually moved are written back into word3 bits 11:0.
`timescale 1ns/1ps
`include "isd_consts.vh"
module isd_desc_engine #(
  parameter UF_CYCLES = `ISD_UFRAME_CYCLES
) (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         txnStart_ff,
  output reg  [3:0]  endpoint_number_ff,
  output reg  [10:0] max_packet_bytes_ff,
  output reg  [14:0] bytes_to_move_ff,
  output reg  [6:0]  txnDevAddr_ff,
  output reg  [1:0]  txnToken_ff,
  output reg         txnSplit_ff,
  output reg  [1:0]  split_speed_field_ff,
  output reg  [6:0]  txnHubAddr_ff,
  output reg  [6:0]  txnPort_ff,
  output reg  [15:0] txnDataAddr_ff,
  input  wire        txnDone,
  input  wire        txnFatal,
  input  wire        txnFinished,
  input  wire [11:0] bytes_moved
);
  localparam S_IDLE = 4'h0;
  localparam S_RD0  = 4'h1;
  localparam S_RD1  = 4'h2;
  localparam S_RD2  = 4'h3;
  localparam S_RD3  = 4'h4;
  localparam S_CHK  = 4'h5;
  localparam S_WAIT = 4'h6;
  localparam S_WB3  = 4'h7;
  localparam S_WB0  = 4'h8;
  localparam S_NEXT = 4'h9;

  // Interval minus one, in microframes, from the polling field
  function [7:0] poll_mask;
    input [4:0] f;
    begin
      if (f[4])          poll_mask = 8'hff;
      else if (f[3])     poll_mask = 8'h7f;
      else if (f[2])     poll_mask = 8'h3f;
      else if (f[1])     poll_mask = 8'h1f;
      else if (f[0])     poll_mask = 8'h0f;
      else               poll_mask = 8'h07;
    end
  endfunction

  reg  [3:0]  state_ff;
  reg  [2:0]  slot_ff;
  reg  [31:0] dw0_ff;
  reg  [31:0] dw1_ff;
  reg  [31:0] dw2_ff;
  reg  [31:0] dw3_ff;
  reg  [11:0] moved_ff;
  reg         clrValid_ff;
  reg  [15:0] ufDiv_ff;
  reg  [7:0]  ufCount_ff;
  reg         tickPend_ff;
  reg         enable_ff;
  reg  [7:0]  awAddr_ff;
  reg  [7:0]  arAddr_ff;
  reg  [31:0] wData_ff;
  reg  [3:0]  wStrb_ff;
  reg         rdPend_ff;
  reg  [4:0]  memAddr;
  reg  [3:0]  memWe;
  reg  [31:0] memWdata;
  wire [31:0] memRdata;

  wire        memFree  = (state_ff == S_IDLE) || (state_ff == S_WAIT);
  wire        wrGo     = memFree && !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire        rdGo     = memFree && !wrGo && !s_axi_arready && !s_axi_rvalid && !rdPend_ff;
  wire        wrIsMem  = awAddr_ff <= `ISD_DESC_TOP;
  wire        rdIsMem  = arAddr_ff <= `ISD_DESC_TOP;
  wire        ufTick   = ufDiv_ff == (UF_CYCLES[15:0] - 16'h0001);
  wire [3:0]  ep       = {dw1_ff[`ISD_DW1_EP_HI:`ISD_DW1_EP_LO], dw0_ff[`ISD_DW0_EP0]};
  wire [10:0] mps      = dw0_ff[`ISD_DW0_MPS_HI:`ISD_DW0_MPS_LO];
  wire [14:0] len      = dw0_ff[`ISD_DW0_LEN_HI:`ISD_DW0_LEN_LO];
  wire [1:0]  se       = dw1_ff[`ISD_DW1_SE_HI:`ISD_DW1_SE_LO];
  wire        isSplit  = dw1_ff[`ISD_DW1_SPLIT];
  wire        isIntr   = dw1_ff[`ISD_DW1_TYPE_HI:`ISD_DW1_TYPE_LO] == `ISD_TYPE_INTR;
  wire        tokBad   = dw1_ff[`ISD_DW1_TOK_HI];
  wire        due      = (ufCount_ff & poll_mask(dw2_ff[`ISD_DW2_POLL_HI:`ISD_DW2_POLL_LO]))
                         == 8'h00;
  wire        seBad    = isSplit && (se != `ISD_SE_LOW) && (se != `ISD_SE_FULL);
  wire        mpsBad   = isSplit && (mps > `ISD_FSLS_MAX_MPS);
  wire        lenBad   = len > `ISD_MAX_LEN;
  wire        reject   = seBad || mpsBad || lenBad || tokBad;

  // ==========================================================
  // Memory port arbitration
  always @* begin
    memAddr  = {slot_ff, 2'b00};
    memWe    = 4'h0;
    memWdata = 32'h0000_0000;
    case (state_ff)
      S_RD1: memAddr = {slot_ff, 2'b01};
      S_RD2: memAddr = {slot_ff, 2'b10};
      S_RD3: memAddr = {slot_ff, 2'b11};
      S_WB3: begin
        memAddr  = {slot_ff, 2'b11};
        memWe    = 4'hf;
        memWdata = {dw3_ff[31:`ISD_DW3_MOVED_HI+1], moved_ff};
      end
      S_WB0: begin
        memWe    = 4'hf;
        memWdata = {dw0_ff[31:1], 1'b0};
      end
      default: begin
        if (wrGo && wrIsMem) begin
          memAddr = awAddr_ff[6:2];
          memWe   = wStrb_ff;
          memWdata = wData_ff;
        end else if (rdGo) begin
          memAddr = arAddr_ff[6:2];
        end
      end
    endcase
  end

  isd_desc_ram u_ram (
    .clk_sys   (clk_sys),
    .addr      (memAddr),
    .wrEn      (memWe),
    .wrData    (memWdata),
    .rdData_ff (memRdata)
  );

  // ==========================================================
  // AXI4-Lite slave
  always @(posedge clk_sys) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ISD_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `ISD_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      awAddr_ff     <= 8'h00;
      arAddr_ff     <= 8'h00;
      wData_ff      <= 32'h0000_0000;
      wStrb_ff      <= 4'h0;
      rdPend_ff     <= 1'b0;
      enable_ff     <= `ISD_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_ff     <= s_axi_wdata;
        wStrb_ff     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrIsMem || awAddr_ff == `ISD_CTRL_ADDR || awAddr_ff == `ISD_STAT_ADDR)
                        ? `ISD_RESP_OKAY : `ISD_RESP_SLVERR;
        if (awAddr_ff == `ISD_CTRL_ADDR && wStrb_ff[0]) begin
          enable_ff <= wData_ff[0];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        arAddr_ff     <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end
      rdPend_ff <= rdGo;
      if (rdPend_ff) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `ISD_RESP_OKAY;
        if (rdIsMem) begin
          s_axi_rdata <= memRdata;
        end else if (arAddr_ff == `ISD_CTRL_ADDR) begin
          s_axi_rdata <= {31'h0000_0000, enable_ff};
        end else if (arAddr_ff == `ISD_STAT_ADDR) begin
          s_axi_rdata <= {16'h0000, ufCount_ff, 1'b0, slot_ff, 3'h0, state_ff != S_IDLE};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `ISD_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Microframe timebase
  always @(posedge clk_sys) begin
    if (!nrst) begin
      ufDiv_ff   <= 16'h0000;
      ufCount_ff <= 8'h00;
    end else if (ufTick) begin
      ufDiv_ff   <= 16'h0000;
      ufCount_ff <= ufCount_ff + 8'h01;
    end else begin
      ufDiv_ff <= ufDiv_ff + 16'h0001;
    end
  end

  // ==========================================================
  // Descriptor scan
  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_ff             <= S_IDLE;
      slot_ff              <= 3'h0;
      dw0_ff               <= 32'h0000_0000;
      dw1_ff               <= 32'h0000_0000;
      dw2_ff               <= 32'h0000_0000;
      dw3_ff               <= 32'h0000_0000;
      moved_ff             <= 12'h000;
      clrValid_ff          <= 1'b0;
      tickPend_ff          <= 1'b0;
      txnStart_ff          <= 1'b0;
      endpoint_number_ff   <= 4'h0;
      max_packet_bytes_ff  <= 11'h000;
      bytes_to_move_ff     <= 15'h0000;
      txnDevAddr_ff        <= 7'h00;
      txnToken_ff          <= 2'b00;
      txnSplit_ff          <= 1'b0;
      split_speed_field_ff <= 2'b00;
      txnHubAddr_ff        <= 7'h00;
      txnPort_ff           <= 7'h00;
      txnDataAddr_ff       <= 16'h0000;
    end else begin
      txnStart_ff <= 1'b0;
      // A tick in the cycle the scan starts still counts
      if (ufTick && enable_ff) begin
        tickPend_ff <= 1'b1;
      end else if (!enable_ff || (state_ff == S_IDLE && tickPend_ff && !wrGo && !rdGo)) begin
        tickPend_ff <= 1'b0;
      end
      case (state_ff)
        S_IDLE: begin
          if (tickPend_ff && enable_ff && !wrGo && !rdGo) begin
            slot_ff  <= 3'h0;
            state_ff <= S_RD0;
          end
        end
        S_RD0: state_ff <= S_RD1;
        S_RD1: begin
          dw0_ff   <= memRdata;
          state_ff <= S_RD2;
        end
        S_RD2: begin
          dw1_ff   <= memRdata;
          state_ff <= S_RD3;
        end
        S_RD3: begin
          dw2_ff   <= memRdata;
          state_ff <= S_CHK;
        end
        S_CHK: begin
          dw3_ff      <= memRdata;
          clrValid_ff <= 1'b1;
          moved_ff    <= 12'h000;
          if (!dw0_ff[`ISD_DW0_VALID] || !isIntr || !due) begin
            state_ff <= S_NEXT;
          end else if (reject) begin
            state_ff <= S_WB0;
          end else begin
            txnStart_ff          <= 1'b1;
            endpoint_number_ff   <= ep;
            max_packet_bytes_ff  <= mps;
            bytes_to_move_ff     <= len;
            txnDevAddr_ff        <= dw1_ff[`ISD_DW1_DEV_HI:`ISD_DW1_DEV_LO];
            txnToken_ff          <= dw1_ff[`ISD_DW1_TOK_HI:`ISD_DW1_TOK_LO];
            txnSplit_ff          <= isSplit;
            split_speed_field_ff <= se;
            txnHubAddr_ff        <= dw1_ff[`ISD_DW1_HUB_HI:`ISD_DW1_HUB_LO];
            txnPort_ff           <= dw1_ff[`ISD_DW1_PORT_HI:`ISD_DW1_PORT_LO];
            txnDataAddr_ff       <= dw2_ff[`ISD_DW2_ADDR_HI:`ISD_DW2_ADDR_LO];
            state_ff             <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (txnDone) begin
            moved_ff    <= bytes_moved;
            clrValid_ff <= txnFatal || txnFinished;
            state_ff    <= S_WB3;
          end
        end
        S_WB3: state_ff <= clrValid_ff ? S_WB0 : S_NEXT;
        // Cached word0 is written back; software edits made during the wait are lost
        S_WB0: state_ff <= S_NEXT;
        S_NEXT: begin
          if (slot_ff == `ISD_LAST_SLOT) begin
            state_ff <= S_IDLE;
          end else begin
            slot_ff  <= slot_ff + 3'h1;
            state_ff <= S_RD0;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // isd_desc_engine

// file: core/isd_desc_ram.v
// Descriptor store: 32 words of 32 bits, byte write enables.
// Assumes one user per cycle; read data are registered.
`timescale 1ns/1ps
module isd_desc_ram (
  input  wire        clk_sys,
  input  wire [4:0]  addr,
  input  wire [3:0]  wrEn,
  input  wire [31:0] wrData,
  output reg  [31:0] rdData_ff
);
  reg [31:0] mem [0:31];
  integer    i;

  always @(posedge clk_sys) begin
    for (i = 0; i < 4; i = i + 1) begin
      if (wrEn[i]) begin
        mem[addr][i*8 +: 8] <= wrData[i*8 +: 8];
      end
    end
    rdData_ff <= mem[addr];
  end
endmodule // isd_desc_ram

// file: verif/isd_props.sv
// Port-level assertions for the descriptor engine.
// Bound into isd_desc_engine from the bench top; one clock domain.
`timescale 1ns/1ps
`include "isd_consts.vh"
module isd_props (
  input logic        clk_sys,
  input logic        nrst,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [1:0]  s_axi_rresp,
  input logic [31:0] s_axi_rdata,
  input logic        txnStart_ff,
  input logic        txnDone,
  input logic        txnFatal,
  input logic [3:0]  endpoint_number_ff,
  input logic [14:0] bytes_to_move_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ========
  // Handshakes
  reset_vals_a: assert property (disable iff (1'b0) !nrst |=> s_axi_awready
    && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !txnStart_ff) else $error("reset state");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
  wr_lock_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("write address reopened early");
  rd_lock_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready [*3])
    else $error("read address reopened early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[3:60] s_axi_rvalid)
    else $error("read never answered");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h87
    |-> ##[3:60] (s_axi_rvalid && s_axi_rresp == `ISD_RESP_SLVERR && s_axi_rdata == 32'h0))
    else $error("unmapped read not refused");
  // ========
  // Transaction port
  start_pulse_a: assert property (txnStart_ff |=> !txnStart_ff) else $error("start too long");
  fields_hold_a: assert property (txnStart_ff |=>
    ($stable(endpoint_number_ff) && $stable(bytes_to_move_ff)) [*4]) else $error("fields moved");
  start_c: cover property (txnStart_ff);
  fatal_c: cover property (txnDone && txnFatal);
  refuse_c: cover property (s_axi_rvalid && s_axi_rresp == `ISD_RESP_SLVERR);
endmodule // isd_props

// file: verif/isd_txn_model.sv
// Transaction engine stand-in: answers each start with one done pulse.
// Assumes the bench sets delay before the start, and outcome and byte count before done.
`timescale 1ns/1ps
module isd_txn_model (
  input  logic        clk_sys,
  input  logic        nrst,
  input  logic        txnStart,
  input  logic [3:0]  delayCfg,
  input  logic        fatalCfg,
  input  logic        finCfg,
  input  logic [11:0] movedCfg,
  output logic        txnDone_ff,
  output logic        txnFatal_ff,
  output logic        txnFinished_ff,
  output logic [11:0] movedOut_ff
);
  logic       busy_ff;
  logic [3:0] cnt_ff;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      txnDone_ff <= 1'b0;
    end else begin
      txnDone_ff <= 1'b0;
      // Outside the done pulse the qualifiers churn, so nothing stale passes
      txnFatal_ff <= ~txnFatal_ff;
      txnFinished_ff <= ~txnFinished_ff;
      movedOut_ff <= ~movedOut_ff;
      if (txnStart && !busy_ff) begin
        busy_ff <= 1'b1;
        cnt_ff <= delayCfg;
      end else if (busy_ff && cnt_ff == 4'h0) begin
        busy_ff <= 1'b0;
        txnDone_ff <= 1'b1;
        txnFatal_ff <= fatalCfg;
        txnFinished_ff <= finCfg;
        movedOut_ff <= movedCfg;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule // isd_txn_model

// file: verif/tb.sv
// Self-checking bench for the descriptor engine.
// Assumes the design under core/ and the transaction model beside it.
`timescale 1ns/1ps
`include "isd_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
module tb;
  localparam int UF = 256;
  logic        clk_sys = 0, nrst = 0;
  logic [7:0]  awAddr = 0, arAddr = 0;
  logic [31:0] wData = 0;
  logic        awV = 0, wV = 0, bRdy = 0, arV = 0, rRdy = 0, fatalCfg = 0, finCfg = 1;
  logic [3:0]  dly = 3;
  logic [11:0] moved = 0;
  wire         awR, wR, bV, arR, rV, start, done, fat, fin, spl;
  wire  [1:0]  bResp, rResp, tok, spd;
  wire  [31:0] rData;
  wire  [3:0]  ep;
  wire  [10:0] mps;
  wire  [14:0] len;
  wire  [11:0] bm;
  wire  [6:0]  dev, hub, port;
  wire  [15:0] da;
  logic [33:0] rq[$], re;
  logic [71:0] fq[$], fe;
  logic [31:0] mem[32];
  int          err_count = 0, tests_run = 0, nStart = 0, stamp[8];
  logic        sawFatal = 0;
  always #2 clk_sys = ~clk_sys;
  isd_desc_engine #(.UF_CYCLES(UF)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awV),
    .s_axi_awready(awR), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wV),
    .s_axi_wready(wR), .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rRdy), .txnStart_ff(start),
    .endpoint_number_ff(ep), .max_packet_bytes_ff(mps), .bytes_to_move_ff(len),
    .txnDevAddr_ff(dev), .txnToken_ff(tok), .txnSplit_ff(spl), .split_speed_field_ff(spd),
    .txnHubAddr_ff(hub), .txnPort_ff(port), .txnDataAddr_ff(da), .txnDone(done), .txnFatal(fat),
    .txnFinished(fin), .bytes_moved(bm));
  isd_txn_model mdl_u (.clk_sys(clk_sys), .nrst(nrst), .txnStart(start), .delayCfg(dly),
    .fatalCfg(fatalCfg), .finCfg(finCfg), .movedCfg(moved), .txnDone_ff(done),
    .txnFatal_ff(fat), .txnFinished_ff(fin), .movedOut_ff(bm));
  // ========
  // Result watchers
  always @(posedge clk_sys) begin
    if (rV && rRdy) begin
      re = rq.pop_front();
      `CHK({rResp, rData}, re)
    end
    if (start) begin
      stamp[nStart % 8] = int'($time);
      nStart++;
      fe = fq.pop_front();
      `CHK({ep, mps, len, tok, spl, spd, dev, hub, port, da}, fe)
    end
    if (done) finCfg <= 1'b0;
    if (done && fat) sawFatal = 1'b1;
  end
  // ========
  // Bus tasks
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    awAddr <= a;
    wData <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    bRdy <= 1'b1;
    while (n < 200) begin
      @(posedge clk_sys);
      n++;
      if (awR) awV <= 1'b0;
      if (wR) wV <= 1'b0;
      if (bV) begin
        bRdy <= 1'b0;
        `CHK(bResp, r)
        n = 1000;
      end
    end
    if (n == 200) err_count++;
  endtask
  task axr(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    @(posedge clk_sys);
    arAddr <= a;
    arV <= 1'b1;
    rRdy <= 1'b1;
    while (n < 200) begin
      @(posedge clk_sys);
      n++;
      if (arR) arV <= 1'b0;
      if (rV) begin
        rRdy <= 1'b0;
        n = 1000;
      end
    end
    if (n == 200) err_count++;
  endtask
  task put(input int i, input logic [31:0] d);
    mem[i] = d;
    axw(8'(i * 4), d, `ISD_RESP_OKAY);
  endtask
  task slot(input int s, input logic [3:0] e, input logic [10:0] m, input logic [14:0] l,
            input logic sp, input logic [1:0] sd, input logic [1:0] tk, input logic [4:0] pl);
    put(s * 4, {e[0], 2'b00, m, l, 2'b00, 1'b1});
    put(s * 4 + 1, {14'($urandom), sd, 1'b0, sp, `ISD_TYPE_INTR, tk, 7'($urandom), e[3:1]});
    put(s * 4 + 2, {8'h0, 16'($urandom), pl, 3'b000});
  endtask
  function automatic logic [71:0] expf(input int s);
    logic [31:0] a, b, c;
    a = mem[s * 4];
    b = mem[s * 4 + 1];
    c = mem[s * 4 + 2];
    return {b[2:0], a[31], a[28:18], a[17:3], b[11:10], b[14], b[17:16],
            b[9:3], b[31:25], b[24:18], c[23:8]};
  endfunction
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ========
  // Tests
  initial begin
    int seed, i;
    seed = $urandom(32'h195851a7);
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    axr(`ISD_CTRL_ADDR, {`ISD_RESP_OKAY, 32'h0});
    axr(8'h88, {`ISD_RESP_SLVERR, 32'h0});
    axw(8'h90, 32'h1, `ISD_RESP_SLVERR);
    $display("test map done");
    for (i = 0; i < 32; i++) put(i, $urandom & 32'hfffffffe);
    put(3, 32'h0);
    slot(0, 4'($urandom), `ISD_FSLS_MAX_MPS, `ISD_MAX_LEN, 1'b1, `ISD_SE_LOW, 2'b01, 5'h0);
    slot(1, 4'($urandom), 11'h041, 15'h10, 1'b1, `ISD_SE_FULL, 2'b01, 5'h0);
    slot(2, 4'($urandom), 11'($urandom), 15'($urandom_range(4096, 1)), 1'b0, 2'b00, 2'b00, 5'h1);
    slot(3, 4'($urandom), 11'h008, 15'h1001, 1'b0, 2'b00, 2'b00, 5'h0);
    slot(4, 4'($urandom), 11'h008, 15'h0008, 1'b1, 2'b01, 2'b00, 5'h0);
    fq.push_back(expf(0));
    repeat (3) fq.push_back(expf(2));
    dly <= 4'(3 + $urandom_range(7));
    moved <= 12'($urandom);
    axw(`ISD_CTRL_ADDR, 32'h1, `ISD_RESP_OKAY);
    axr(`ISD_CTRL_ADDR, {`ISD_RESP_OKAY, 32'h1});
    i = 0;
    while (nStart < 4 && i < 40000) begin
      @(posedge clk_sys);
      i++;
    end
    if (nStart < 4) err_count++;
    fatalCfg <= 1'b1;
    `CHK(stamp[3] - stamp[2], 16 * UF * 4)
    $display("test poll done");
    i = 0;
    while (!sawFatal && i < 5000) begin
      @(posedge clk_sys);
      i++;
    end
    if (!sawFatal) err_count++;
    // Word3 then word0 land one cycle apart after done
    repeat (4) @(posedge clk_sys);
    axr(8'h0c, {2'b00, 20'h0, moved});
    axr(8'h00, {2'b00, mem[0] & 32'hfffffffe});
    axr(8'h10, {2'b00, mem[4] & 32'hfffffffe});
    axr(8'h1c, {2'b00, mem[7]});
    axr(8'h20, {2'b00, mem[8] & 32'hfffffffe});
    axr(8'h30, {2'b00, mem[12] & 32'hfffffffe});
    axr(8'h40, {2'b00, mem[16] & 32'hfffffffe});
    axr(8'h50, {2'b00, mem[20]});
    repeat (32 * UF) @(posedge clk_sys);
    `CHK(nStart, 4)
    $display("test clear done");
    final_report;
  end
  initial begin
    #300000;
    err_count++;
    final_report;
  end
endmodule // tb
bind isd_desc_engine isd_props chk_u (.clk_sys(clk_sys), .nrst(nrst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
  .txnStart_ff(txnStart_ff), .txnDone(txnDone), .txnFatal(txnFatal),
  .endpoint_number_ff(endpoint_number_ff), .bytes_to_move_ff(bytes_to_move_ff));
